// file: src/psr_pkg.sv
// Package for the power status and reset control block.
// Assumes a single 200 MHz clock and a 16-bit register port with byte addresses.
package psr_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses as printed)
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_PIN_RESET_HOLD_TIME     = 32'h0500_0042;
  localparam logic [31:0] ADDR_ANALOG_SUPPLY_STATUS    = 32'h5000_002A;
  localparam logic [31:0] ADDR_CRYSTAL_START_TRIM      = 32'h5000_0030;
  localparam logic [31:0] ADDR_CRYSTAL_READY_DELAY     = 32'h5000_0034;
  localparam logic [31:0] ADDR_CRYSTAL_CORE_CONTROL    = 32'h5000_0038;
  localparam logic [31:0] ADDR_PIN_RESET_SELECT        = 32'h5000_0040;
  localparam logic [31:0] ADDR_SLEEP_REFERENCE_REFRESH = 32'h5000_0050;
  localparam logic [31:0] ADDR_SUPPLY_SWITCH_CONTROL   = 32'h5000_0052;

  // ----------------------------------------------------------------
  // Reset values and field layouts
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_HOLD_TIME      = 16'h0018;
  localparam logic [15:0] RST_START_TRIM     = 16'h00AA;
  localparam logic [15:0] RST_READY_DELAY    = 16'h0000;
  localparam logic [15:0] RST_CORE_CONTROL   = 16'h0015;
  localparam logic [15:0] RST_PIN_SELECT     = 16'h0000;
  localparam logic [15:0] RST_REFRESH        = 16'h0080;
  localparam logic [15:0] RST_SWITCH_CONTROL = 16'h0000;

  localparam logic [15:0] MASK_HOLD_TIME      = 16'h007F;
  localparam logic [15:0] MASK_READY_DELAY    = 16'h00FF;
  localparam logic [15:0] MASK_CORE_CONTROL   = 16'h00FF;
  localparam logic [15:0] MASK_PIN_SELECT     = 16'h00FF;
  localparam logic [15:0] MASK_REFRESH        = 16'h0FFF;
  localparam logic [15:0] MASK_SWITCH_CONTROL = 16'h8000;

  localparam int POS_PIN_POLARITY = 7;
  localparam int POS_SWITCH_MODE  = 15;
  localparam int POS_BOOST        = 8;

  localparam logic [3:0] SEL_DISABLED = 4'h0;
  localparam logic [3:0] SEL_LAST     = 4'hC;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ          = 200_000_000;
  localparam int SLOW_HZ           = 32_000;
  localparam int SLOW_DIV          = CLOCK_HZ / SLOW_HZ;
  localparam int HOLD_UNIT_CYCLES  = 4096;
  localparam int REFRESH_UNIT_MS   = 2;
  localparam int REFRESH_UNIT_SLOW = REFRESH_UNIT_MS * SLOW_HZ / 1000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } psr_bus_req_t;

  typedef struct packed {
    logic wake_tree_output;
    logic adc_regulator_good;
    logic crystal_regulator_good;
    logic boost_detected;
    logic rail_high_monitor;
    logic rail_low_monitor;
    logic bandgap_good;
    logic rail_high_below;
    logic rail_high_above;
    logic rail_high_good;
    logic rail_low_good;
    logic low_regulator_good;
    logic core_regulator_good;
  } psr_analog_t;

endpackage

// file: src/psr_slow_tick.sv
// Divider that makes the 32 kHz enable pulse from the fast clock.
// Assumes one clock domain; the pulse is one clock wide.
`timescale 1ns/1ps
`default_nettype none
module psr_slow_tick #(
  parameter int DIV = 6250
) (
  input  wire logic clock,
  input  wire logic rstn,
  output logic      tick
);
  localparam int W = $clog2(DIV);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  if (DIV < 2) begin : g_bad
    $error("Divider must be at least two.");
  end

  typedef struct packed {
    logic [W-1:0] count;
    logic         tick;
  } psr_tick_state_t;

  psr_tick_state_t state;
  psr_tick_state_t next_state;

  // Count down and pulse once per period.
  always_comb
  begin
    next_state = state;
    next_state.tick = 1'b0;
    if (state.count == '0)
    begin
      next_state.count = W'(DIV - 1);
      next_state.tick = 1'b1;
    end
    else
    begin
      next_state.count = state.count - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      state <= '0;
    else
      state <= next_state;
  end

  assign tick = state.tick;
endmodule
`default_nettype wire

// file: src/psr_ctrl.sv
// Power status, crystal timing, pin reset and reference refresh registers.
// Assumes a register master on the same clock and analog indicators that are asynchronous.
// Behaviour
// - Wake tree output readable; low wakes chip
// - Rail monitors report 0 low, 1 good
// - Flags for upper rail 50 mV below/above
// - Topology bit: 0 buck, 1 boost
// - Converter good follows rail per topology
// - Low regulator good valid in high-current only
// - Regulator and bandgap good flags read zero after reset
// - Count slow cycles, then crystal ready interrupt
// - Ramp trim upper byte, start trim 0xAA
// - Polarity bit applies to GPIO input only
// - Four-bit selector picks reset GPIO or none
// - Reset after hold value times 4096 slow cycles
// - Hold value zero disables pin reset
// - Periodic bandgap refresh in 2 ms units
// - Mode bit selects manual or automatic switch
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module psr_ctrl
  import psr_pkg::*;
#(
  parameter int NUM_PINS   = 12,
  parameter int HOLD_UNIT  = psr_pkg::HOLD_UNIT_CYCLES,
  parameter int SLOW_DIV_P = psr_pkg::SLOW_DIV
) (
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire psr_pkg::psr_bus_req_t bus_req,
  output logic [15:0]               rdata,
  input  wire psr_pkg::psr_analog_t analog_in,
  input  wire logic [NUM_PINS-1:0]  gpio_in,
  input  wire logic                 reset_pad_n,
  input  wire logic                 crystal_enable,
  input  wire logic                 sleep_active,
  output logic                      crystal_ready_interrupt,
  output logic                      pin_reset,
  output logic                      reference_refresh,
  output logic                      rail_switch_mode,
  output logic                      rail_switch_auto
);
  import psr_pkg::*;

  localparam int HW = $clog2(HOLD_UNIT) + 7;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_PINS < 1 || NUM_PINS > 12) begin : g_bad_pins
    $error("Selector can address one to twelve pins.");
  end
  if (HOLD_UNIT < 1) begin : g_bad_unit
    $error("Hold unit must be positive.");
  end

  // Whether an address hits a register, used by read and write decode.
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  localparam int SW = $bits(psr_analog_t) + NUM_PINS + 3;
  // The pad bit sits third from the bottom and idles high, so a flop reset must not look like a pressed pad.
  localparam logic [SW-1:0] SYNC_IDLE = SW'(3'b100);
  logic [SW-1:0] sync_a;
  logic [SW-1:0] sync_b;

  // Two flops for everything from pins and analog comparators.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sync_a <= SYNC_IDLE;
      sync_b <= SYNC_IDLE;
    end
    else
    begin
      sync_a <= {analog_in, gpio_in, reset_pad_n, crystal_enable, sleep_active};
      sync_b <= sync_a;
    end
  end

  psr_analog_t         ana;
  logic [NUM_PINS-1:0] gpio_s;
  logic                pad_n_s;
  logic                xtal_en_s;
  logic                sleep_s;
  assign {ana, gpio_s, pad_n_s, xtal_en_s, sleep_s} = sync_b;

  // ----------------------------------------------------------------
  // Slow clock enable
  // ----------------------------------------------------------------
  logic slow_tick;

  psr_slow_tick #(
    .DIV (SLOW_DIV_P)
  ) u_tick (
    .clock (clock),
    .rstn  (rstn),
    .tick  (slow_tick)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]   hold_time;
    logic [15:0]   start_trim;
    logic [15:0]   ready_delay;
    logic [15:0]   core_control;
    logic [15:0]   pin_select;
    logic [15:0]   refresh;
    logic [15:0]   switch_control;
    logic [15:0]   rdata;
    logic [7:0]    ready_count;
    logic          ready_running;
    logic          xtal_en_d;
    logic          ready_irq;
    logic [HW-1:0] hold_count;
    logic          pin_reset;
    logic [11:0]   refresh_units;
    logic [15:0]   refresh_sub;
    logic          refresh_pulse;
  } psr_state_t;

  psr_state_t state;
  psr_state_t next_state;

  // Status word, sampled live on each read.
  logic [15:0] status_word;
  logic        converter_good;
  logic        pin_asserted;
  logic [3:0]  sel;
  logic [HW-1:0] hold_target;

  assign converter_good = ana.boost_detected ? ana.rail_high_good : ana.rail_low_good;

  // Status bit layout; bit 11 and the top bits read zero.
  always_comb
  begin
    status_word = '0;
    status_word[12] = ana.wake_tree_output;
    status_word[10] = ana.adc_regulator_good;
    status_word[9] = ana.crystal_regulator_good;
    status_word[POS_BOOST] = ana.boost_detected;
    status_word[7] = ana.rail_high_monitor;
    status_word[6] = ana.rail_low_monitor;
    status_word[5] = ana.bandgap_good;
    status_word[4] = ana.rail_high_below;
    status_word[3] = ana.rail_high_above;
    status_word[2] = converter_good;
    status_word[1] = ana.low_regulator_good;
    status_word[0] = ana.core_regulator_good;
  end

  always_comb
  begin
    sel = state.pin_select[3:0];
    pin_asserted = 1'b0;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (sel == 4'(i + 1))
      begin
        pin_asserted = state.pin_select[POS_PIN_POLARITY] ? gpio_s[i] : !gpio_s[i];
      end
    end
  end

  assign hold_target = HW'(state.hold_time[6:0]) * HW'(HOLD_UNIT);

  // Next-state logic for registers and timers.
  always_comb
  begin
    next_state = state;
    next_state.refresh_pulse = 1'b0;
    next_state.xtal_en_d = xtal_en_s;

    // Register writes; read-only status takes no write.
    if (bus_req.wr)
    begin
      if (hit(bus_req.addr, ADDR_PIN_RESET_HOLD_TIME))
        next_state.hold_time = bus_req.wdata & MASK_HOLD_TIME;
      if (hit(bus_req.addr, ADDR_CRYSTAL_START_TRIM))
        next_state.start_trim = bus_req.wdata;
      if (hit(bus_req.addr, ADDR_CRYSTAL_READY_DELAY))
        next_state.ready_delay = bus_req.wdata & MASK_READY_DELAY;
      if (hit(bus_req.addr, ADDR_CRYSTAL_CORE_CONTROL))
        next_state.core_control = bus_req.wdata & MASK_CORE_CONTROL;
      if (hit(bus_req.addr, ADDR_PIN_RESET_SELECT))
        next_state.pin_select = bus_req.wdata & MASK_PIN_SELECT;
      if (hit(bus_req.addr, ADDR_SLEEP_REFERENCE_REFRESH))
        next_state.refresh = bus_req.wdata & MASK_REFRESH;
      if (hit(bus_req.addr, ADDR_SUPPLY_SWITCH_CONTROL))
        next_state.switch_control = bus_req.wdata & MASK_SWITCH_CONTROL;
    end

    // Read data stand one cycle after the strobe; unmapped reads give zero.
    next_state.rdata = '0;
    if (bus_req.rd)
    begin
      if (hit(bus_req.addr, ADDR_ANALOG_SUPPLY_STATUS))
        next_state.rdata = status_word;
      else if (hit(bus_req.addr, ADDR_PIN_RESET_HOLD_TIME))
        next_state.rdata = state.hold_time;
      else if (hit(bus_req.addr, ADDR_CRYSTAL_START_TRIM))
        next_state.rdata = state.start_trim;
      else if (hit(bus_req.addr, ADDR_CRYSTAL_READY_DELAY))
        next_state.rdata = state.ready_delay;
      else if (hit(bus_req.addr, ADDR_CRYSTAL_CORE_CONTROL))
        next_state.rdata = state.core_control;
      else if (hit(bus_req.addr, ADDR_PIN_RESET_SELECT))
        next_state.rdata = state.pin_select;
      else if (hit(bus_req.addr, ADDR_SLEEP_REFERENCE_REFRESH))
        next_state.rdata = state.refresh;
      else if (hit(bus_req.addr, ADDR_SUPPLY_SWITCH_CONTROL))
        next_state.rdata = state.switch_control;
    end

    next_state.ready_irq = 1'b0;
    if (!xtal_en_s)
    begin
      next_state.ready_running = 1'b0;
    end
    else if (xtal_en_s && !state.xtal_en_d && state.ready_delay[7:0] != 8'h00)
    begin
      next_state.ready_running = 1'b1;
      next_state.ready_count = state.ready_delay[7:0];
    end
    else if (state.ready_running && slow_tick)
    begin
      if (state.ready_count == 8'h01)
      begin
        next_state.ready_running = 1'b0;
        next_state.ready_irq = 1'b1;
      end
      next_state.ready_count = state.ready_count - 8'h01;
    end

    if (!pin_asserted || sel == SEL_DISABLED || sel > SEL_LAST)
    begin
      next_state.hold_count = '0;
      next_state.pin_reset = 1'b0;
    end
    else if (state.hold_time[6:0] == 7'h00)
    begin
      next_state.hold_count = '0;
      next_state.pin_reset = 1'b0;
    end
    else if (slow_tick && !state.pin_reset)
    begin
      if (state.hold_count + 1'b1 >= hold_target)
        next_state.pin_reset = 1'b1;
      next_state.hold_count = state.hold_count + 1'b1;
    end

    if (!sleep_s)
    begin
      next_state.refresh_units = '0;
      next_state.refresh_sub = '0;
    end
    else if (slow_tick)
    begin
      if (state.refresh_sub == 16'(REFRESH_UNIT_SLOW - 1))
      begin
        next_state.refresh_sub = '0;
        if (state.refresh_units + 1'b1 >= state.refresh[11:0])
        begin
          next_state.refresh_units = '0;
          next_state.refresh_pulse = 1'b1;
        end
        else
        begin
          next_state.refresh_units = state.refresh_units + 1'b1;
        end
      end
      else
      begin
        next_state.refresh_sub = state.refresh_sub + 16'h0001;
      end
    end
  end

  // State register with documented reset values.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= '0;
      state.hold_time <= RST_HOLD_TIME;
      state.start_trim <= RST_START_TRIM;
      state.ready_delay <= RST_READY_DELAY;
      state.core_control <= RST_CORE_CONTROL;
      state.pin_select <= RST_PIN_SELECT;
      state.refresh <= RST_REFRESH;
      state.switch_control <= RST_SWITCH_CONTROL;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata = state.rdata;
  assign crystal_ready_interrupt = state.ready_irq;
  // The reset pad keeps its own fixed active-low sense.
  assign pin_reset = state.pin_reset | !pad_n_s;
  assign reference_refresh = state.refresh_pulse;
  assign rail_switch_mode = state.switch_control[POS_SWITCH_MODE];
  assign rail_switch_auto = state.switch_control[POS_SWITCH_MODE] & ana.boost_detected;
endmodule
`default_nettype wire

// file: test/psr_ctrl_properties.sv
// Port checker for the power status and reset control block.
// Assumes it is bound onto psr_ctrl and sees one clock with reset rstn.
`timescale 1ns/1ps
`default_nettype none
module psr_ctrl_properties
  import psr_pkg::*;
#(
  parameter int NUM_PINS   = 12,
  parameter int HOLD_UNIT  = 4096,
  parameter int SLOW_DIV_P = 6250
) (
  input wire logic                  clock,
  input wire logic                  rstn,
  input wire psr_pkg::psr_bus_req_t bus_req,
  input wire logic [15:0]           rdata,
  input wire psr_pkg::psr_analog_t  analog_in,
  input wire logic [NUM_PINS-1:0]   gpio_in,
  input wire logic                  reset_pad_n,
  input wire logic                  crystal_enable,
  input wire logic                  sleep_active,
  input wire logic                  crystal_ready_interrupt,
  input wire logic                  pin_reset,
  input wire logic                  reference_refresh,
  input wire logic                  rail_switch_mode,
  input wire logic                  rail_switch_auto
);
  import psr_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // ------------------------------------------------------------
  // Status reads and output checks
  // ------------------------------------------------------------
  // Steady levels are needed because the inputs pass two sync flops.
  sequence s_st_rd;
    $stable(analog_in) [*4] ##0 (bus_req.rd && bus_req.addr == ADDR_ANALOG_SUPPLY_STATUS);
  endsequence
  sequence s_sw_wr;
    bus_req.wr && bus_req.addr == ADDR_SUPPLY_SWITCH_CONTROL;
  endsequence

  a_wake_bit: assert property (s_st_rd |=> rdata[12] == $past(analog_in.wake_tree_output))
    else $error("wake tree bit wrong");
  a_rail_bits: assert property (s_st_rd |=> rdata[7:6] == $past({analog_in.rail_high_monitor,
    analog_in.rail_low_monitor})) else $error("rail monitor bits wrong");
  a_topology_bit: assert property (s_st_rd |=> rdata[8] == $past(analog_in.boost_detected))
    else $error("topology bit wrong");
  a_conv_good: assert property (s_st_rd |=> rdata[2] == $past(analog_in.boost_detected ?
    analog_in.rail_high_good : analog_in.rail_low_good)) else $error("converter good wrong");
  a_irq_pulse: assert property (crystal_ready_interrupt |=> !crystal_ready_interrupt)
    else $error("ready pulse too long");
  a_refresh_gap: assert property (reference_refresh |=> !reference_refresh [*8])
    else $error("refresh pulses too close");
  a_refresh_sleep: assert property (reference_refresh |-> $past(sleep_active, 3))
    else $error("refresh outside sleep");
  a_mode_write: assert property (s_sw_wr |=> rail_switch_mode == $past(bus_req.wdata[15]))
    else $error("switch mode not written");
  a_auto_boost: assert property ((rail_switch_mode && analog_in.boost_detected) [*3] |-> rail_switch_auto)
    else $error("auto switch missing");
  a_pad_fixed: assert property ((!reset_pad_n) [*3] |-> pin_reset)
    else $error("pad reset missing");
endmodule

bind psr_ctrl psr_ctrl_properties #(.NUM_PINS(NUM_PINS), .HOLD_UNIT(HOLD_UNIT), .SLOW_DIV_P(SLOW_DIV_P))
  psr_ctrl_properties_i (.clock(clock), .rstn(rstn), .bus_req(bus_req), .rdata(rdata), .analog_in(analog_in),
  .gpio_in(gpio_in), .reset_pad_n(reset_pad_n), .crystal_enable(crystal_enable), .sleep_active(sleep_active),
  .crystal_ready_interrupt(crystal_ready_interrupt), .pin_reset(pin_reset), .rail_switch_auto(rail_switch_auto),
  .reference_refresh(reference_refresh), .rail_switch_mode(rail_switch_mode));
`default_nettype wire

// file: test/test_power_status_reset_ctrl.sv
// Self-checking bench for the power status and reset control block.
// Assumes shortened slow counts: two slow ticks a hold unit, four clocks a tick.
`timescale 1ns/1ps
`default_nettype none
module test_power_status_reset_ctrl;
  import psr_pkg::*;
  localparam int HU = 2;
  localparam int DV = 4;
  logic         clock;
  logic         rstn;
  psr_bus_req_t breq;
  logic [15:0]  rdata;
  psr_analog_t  analog;
  logic [11:0]  gpio;
  logic         pad_n;
  logic         xen;
  logic         sleep;
  logic         irq;
  logic         prst;
  logic         refr;
  logic         smode;
  logic         sauto;
  int           n_mismatch;
  int           compares;

  psr_ctrl #(.NUM_PINS(12), .HOLD_UNIT(HU), .SLOW_DIV_P(DV)) psr_ctrl_i (
    .clock(clock), .rstn(rstn), .bus_req(breq), .rdata(rdata), .analog_in(analog), .gpio_in(gpio),
    .reset_pad_n(pad_n), .crystal_enable(xen), .sleep_active(sleep), .crystal_ready_interrupt(irq),
    .pin_reset(prst), .reference_refresh(refr), .rail_switch_mode(smode), .rail_switch_auto(sauto));

  // Clock of 5 ns period.
  always #2.5 clock = ~clock;

  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One idle edge after the release keeps the next call from driving the strobe again in this time step.
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    breq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    breq <= '0;
    @(posedge clock);
  endtask

  task automatic rc(input logic [31:0] a, input logic [15:0] e);
    breq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    breq <= '0;
    // Read data stand in the cycle after the strobe and are taken at its closing edge.
    @(posedge clock);
    chk(rdata, e);
  endtask

  // Counts clocks until the chosen output is high, at most lim.
  task automatic wt(input int s, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end while (n < lim && (s == 0 ? irq : s == 1 ? prst : refr) !== 1'b1);
  endtask

  function automatic logic [15:0] st(input psr_analog_t a);
    st = {3'h0, a.wake_tree_output, 1'b0, a.adc_regulator_good, a.crystal_regulator_good, a.boost_detected,
          a.rail_high_monitor, a.rail_low_monitor, a.bandgap_good, a.rail_high_below, a.rail_high_above,
          a.boost_detected ? a.rail_high_good : a.rail_low_good, a.low_regulator_good, a.core_regulator_good};
  endfunction

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rc(ADDR_ANALOG_SUPPLY_STATUS, 16'h0000);
    rc(ADDR_CRYSTAL_START_TRIM, RST_START_TRIM);
    rc(ADDR_CRYSTAL_READY_DELAY, RST_READY_DELAY);
    rc(ADDR_PIN_RESET_SELECT, RST_PIN_SELECT);
    rc(ADDR_PIN_RESET_HOLD_TIME, RST_HOLD_TIME);
    rc(ADDR_SLEEP_REFERENCE_REFRESH, RST_REFRESH);
    rc(32'h5000_0060, 16'h0000);
  endtask

  task automatic t_regs;
    wr(ADDR_CRYSTAL_START_TRIM, 16'hFF55);
    rc(ADDR_CRYSTAL_START_TRIM, 16'hFF55);
    wr(ADDR_PIN_RESET_HOLD_TIME, 16'hFFFF);
    rc(ADDR_PIN_RESET_HOLD_TIME, MASK_HOLD_TIME);
    wr(ADDR_SLEEP_REFERENCE_REFRESH, 16'hFFFF);
    rc(ADDR_SLEEP_REFERENCE_REFRESH, MASK_REFRESH);
    wr(ADDR_ANALOG_SUPPLY_STATUS, 16'hFFFF);
    rc(ADDR_ANALOG_SUPPLY_STATUS, 16'h0000);
    wr(ADDR_SUPPLY_SWITCH_CONTROL, 16'hFFFF);
    rc(ADDR_SUPPLY_SWITCH_CONTROL, 16'h8000);
    analog <= psr_analog_t'(13'h0200);
    repeat (4) @(posedge clock);
    chk({14'h0, smode, sauto}, 16'h0003);
    analog <= '0;
    repeat (4) @(posedge clock);
    chk({14'h0, smode, sauto}, 16'h0002);
    wr(ADDR_SUPPLY_SWITCH_CONTROL, 16'h0000);
  endtask

  // Patterns pair boost and buck with one good rail to expose the wrong pick.
  task automatic t_status;
    logic [12:0] p [6] = '{13'h1FFF, 13'h0208, 13'h0008, 13'h0DB4, 13'h1000, 13'h0004};
    foreach (p[i])
    begin
      analog <= psr_analog_t'(p[i]);
      repeat (4) @(posedge clock);
      rc(ADDR_ANALOG_SUPPLY_STATUS, st(psr_analog_t'(p[i])));
    end
    analog <= '0;
  endtask

  task automatic t_xtal;
    int n;
    wr(ADDR_CRYSTAL_READY_DELAY, 16'h0003);
    xen <= 1'b1;
    wt(0, 100, n);
    chk({15'h0, n >= 2 * DV && n <= 3 * DV + 8}, 16'h0001);
    xen <= 1'b0;
    wr(ADDR_CRYSTAL_READY_DELAY, 16'h0000);
    repeat (4) @(posedge clock);
    xen <= 1'b1;
    wt(0, 60, n);
    chk(n[15:0], 16'd60);
    xen <= 1'b0;
  endtask

  task automatic t_pin;
    int n;
    wr(ADDR_PIN_RESET_HOLD_TIME, 16'h0002);
    wr(ADDR_PIN_RESET_SELECT, 16'h0084);
    gpio[2] <= 1'b1;
    wt(1, 60, n);
    chk(n[15:0], 16'd60);
    gpio[3] <= 1'b1;
    repeat (8) @(posedge clock);
    gpio[3] <= 1'b0;
    repeat (2) @(posedge clock);
    gpio[3] <= 1'b1;
    wt(1, 100, n);
    chk({15'h0, n >= (2 * HU - 1) * DV && n <= 2 * HU * DV + 8}, 16'h0001);
    gpio <= '0;
    repeat (4) @(posedge clock);
    chk({15'h0, prst}, 16'h0000);
    wr(ADDR_PIN_RESET_SELECT, 16'h0000);
    gpio <= 12'hFFF;
    wr(ADDR_PIN_RESET_SELECT, 16'h0004);
    gpio[3] <= 1'b0;
    wt(1, 100, n);
    chk({15'h0, n >= (2 * HU - 1) * DV && n <= 2 * HU * DV + 8}, 16'h0001);
    gpio <= 12'hFFF;
    wr(ADDR_PIN_RESET_HOLD_TIME, 16'h0000);
    gpio[3] <= 1'b0;
    wt(1, 60, n);
    chk(n[15:0], 16'd60);
    wr(ADDR_PIN_RESET_HOLD_TIME, 16'h0002);
    wr(ADDR_PIN_RESET_SELECT, 16'h000D);
    gpio <= '0;
    wt(1, 60, n);
    chk(n[15:0], 16'd60);
    pad_n <= 1'b0;
    repeat (4) @(posedge clock);
    chk({15'h0, prst}, 16'h0001);
    pad_n <= 1'b1;
  endtask

  task automatic t_refresh;
    int n;
    wr(ADDR_SLEEP_REFERENCE_REFRESH, 16'h0001);
    sleep <= 1'b1;
    wt(2, 600, n);
    wt(2, 600, n);
    chk(n[15:0], 16'(64 * DV));
    sleep <= 1'b0;
  endtask

  task automatic final_report;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    {clock, rstn, xen, sleep, n_mismatch, compares} = '0;
    breq = '0;
    analog = '0;
    gpio = '0;
    pad_n = 1'b1;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    // No false pad reset may show in the two edges after release.
    repeat (2)
    begin
      @(posedge clock);
      chk({15'h0, prst}, 16'h0000);
    end
    repeat (2) @(posedge clock);
    t_reset;
    t_regs;
    t_status;
    t_xtal;
    t_pin;
    t_refresh;
    final_report;
  end

  // Watchdog well beyond the thousand or so cycles the scenarios need.
  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    final_report;
  end
endmodule
`default_nettype wire
